//--- logic/fhbp_regs.vh
// Purpose: constants of the framer host bus port
// Assumes: 7-bit byte addresses, 8-bit internal registers
// Notes:   definitions only
`ifndef FHBP_REGS_VH
`define FHBP_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// pin bundle passed through the synchroniser, msb first
`define FHBP_PIN_W      30
`define FHBP_PIN_RST    30'h3a000000
`define FHBP_P_CS       29
`define FHBP_P_RD       28
`define FHBP_P_WR       27
`define FHBP_P_ALE      26
`define FHBP_P_BE       25
`define FHBP_P_STYLE    24
`define FHBP_P_WIDTH    23
`define FHBP_P_ADDR_HI  22
`define FHBP_P_ADDR_LO  16
`define FHBP_P_DATA_HI  15

////////////////////////////////////////////////////////////////////////////////
// register map
`define FHBP_NREG       128
`define FHBP_ICFG_ADDR  7'h08
`define FHBP_IMR_BASE   7'h20
`define FHBP_ISR_BASE   7'h68
`define FHBP_GSTAT_ADDR 7'h6e
`define FHBP_NGRP       6
`define FHBP_GRP_HOLE   3'h4
`define FHBP_GRP_NONE   3'h7
`define FHBP_IMR_RST    8'hff
`define FHBP_REG_RST    8'h00

////////////////////////////////////////////////////////////////////////////////
// interrupt pin types held in the low bits of the pin configuration
`define FHBP_INT_OD     2'h0
`define FHBP_INT_PP_LO  2'h1
`define FHBP_INT_PP_HI  2'h3

`endif

//--- logic/fhbp_sync.v
// Purpose: three-flop synchroniser for asynchronous host pins
// Assumes: one clock domain
// Notes:   a bit changes only once stages two and three agree
`timescale 1ns/1ps

module fhbp_sync #(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // clock and reset
    input  wire         ref_clk_i,
    input  wire         nrst_i,
    // pins
    input  wire [W-1:0] pin_i,
    output reg  [W-1:0] q_o
);

reg [W-1:0] s1;
reg [W-1:0] s2;
reg [W-1:0] s3;

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        s1  <= RST;
        s2  <= RST;
        s3  <= RST;
        q_o <= RST;
    end else begin
        s1  <= pin_i;
        s2  <= s1;
        s3  <= s2;
        // filters a bit caught mid-transition
        q_o <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & q_o);
    end
end

endmodule

//--- logic/fhbp_irq_pin.v
// Purpose: drives the interrupt request pin in the programmed style
// Assumes: request is a level from the same clock
// Notes:   output enable is low while the pin is driven
`timescale 1ns/1ps
`include "fhbp_regs.vh"

module fhbp_irq_pin (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       nrst_i,
    // control
    input  wire       req_i,
    input  wire [1:0] mode_i,
    // pin
    output reg        int_o,
    output reg        int_oe_n_o
);

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        int_o      <= 1'b1;
        int_oe_n_o <= 1'b1;
    end else begin
        if (mode_i == `FHBP_INT_PP_HI) begin
            int_o      <= req_i;
            int_oe_n_o <= 1'b0;
        end else if (mode_i == `FHBP_INT_PP_LO) begin
            int_o      <= ~req_i;
            int_oe_n_o <= 1'b0;
        end else begin
            // open drain: only pull low, release otherwise
            int_o      <= 1'b0;
            int_oe_n_o <= ~req_i;
        end
    end
end

endmodule

//--- logic/fhbp_port.v
// What this block does
// - In separate-strobe style a selected read strobe puts the addressed register on the bus.
// - In separate-strobe style a selected write strobe loads the addressed register from the bus.
// - In strobe-plus-direction style the data strobe and chip select are ORed active low.
// - In strobe-plus-direction style the direction pin picks read or write for each access.
// - Width select low gives an 8-bit bus, high gives a 16-bit bus.
// - The 16-bit bus carries words and bytes, lanes picked by address bit 0 and byte enable.
// - Style select low gives separate strobes, high gives strobe plus direction.
// - In separate-strobe style on the wide bus the byte enable marks use of the upper byte.
// - In strobe-plus-direction style on the wide bus the byte enable marks use of the lower byte.
// - On the narrow bus the byte enable is ignored and the host should tie it high.
// - One interrupt output combines all sources, each maskable through six mask registers.
// - Status is read from a global status register and status registers 0 to 3 and 5.
// - The interrupt pin is push-pull low, push-pull high or open drain by configuration.
// - Chip select low selects the device and strobes are ignored while it is high.
// - In multiplexed operation the address is latched on the falling edge of address latch.
// - On byte transfers over the wide bus the unused lane stays undriven.
//
// Purpose: host processor port, register file and interrupt status
// Assumes: all host pins are asynchronous and pass a three-flop filter
// Notes:   writes commit at the trailing edge of the write access
`timescale 1ns/1ps
`include "fhbp_regs.vh"

module fhbp_port (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    // host strobes and straps
    input  wire        cs_n_i,
    input  wire        rd_strobe_n_i,
    input  wire        wr_n_dir_i,
    input  wire        ale_i,
    input  wire        byte_enable_n_i,
    input  wire        bus_style_select_i,
    input  wire        bus_width_select_i,
    // host address and data
    input  wire [6:0]  addr_i,
    input  wire [15:0] data_i,
    output reg  [15:0] data_o,
    output reg  [15:0] data_oe_n_o,
    // interrupt sources, groups 0..3 then 5
    input  wire [39:0] irq_evt_i,
    // interrupt pin
    output wire        int_o,
    output wire        int_oe_n_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser

wire [`FHBP_PIN_W-1:0] pins;

fhbp_sync #(
    .W   (`FHBP_PIN_W),
    .RST (`FHBP_PIN_RST)
) u_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     ({cs_n_i, rd_strobe_n_i, wr_n_dir_i, ale_i, byte_enable_n_i,
                 bus_style_select_i, bus_width_select_i, addr_i, data_i}),
    .q_o       (pins)
);

wire        s_cs_n  = pins[`FHBP_P_CS];
wire        s_rd_n  = pins[`FHBP_P_RD];
wire        s_wr    = pins[`FHBP_P_WR];
wire        s_ale   = pins[`FHBP_P_ALE];
wire        s_be_n  = pins[`FHBP_P_BE];
wire        s_style = pins[`FHBP_P_STYLE];
wire        s_wide  = pins[`FHBP_P_WIDTH];
wire [6:0]  s_addr  = pins[`FHBP_P_ADDR_HI:`FHBP_P_ADDR_LO];
wire [15:0] s_data  = pins[`FHBP_P_DATA_HI:0];

////////////////////////////////////////////////////////////////////////////////
// storage

reg [7:0] regs [0:`FHBP_NREG-1];
reg [7:0] isr  [0:`FHBP_NGRP-1];
reg [5:0] global_irq_status;

reg        ale_q;
reg        ale_seen;
reg [6:0]  addr_lat;
reg        rd_q;
reg        wr_q;
reg [15:0] w_data;
reg        w_lo_en;
reg        w_hi_en;
reg [6:0]  w_lo_a;
reg [6:0]  w_hi_a;
reg        r_lo_en;
reg        r_hi_en;
reg [6:0]  r_lo_a;
reg [6:0]  r_hi_a;
reg [7:0]  r_lo_d;
reg [7:0]  r_hi_d;

////////////////////////////////////////////////////////////////////////////////
// helpers

// status group index of an address, none for everything else
function [2:0] grp_of;
    input [6:0] a;
    reg   [6:0] d;
    begin
        d = a - `FHBP_ISR_BASE;
        if (a >= `FHBP_ISR_BASE && d < `FHBP_NGRP && d[2:0] != `FHBP_GRP_HOLE)
            grp_of = d[2:0];
        else
            grp_of = `FHBP_GRP_NONE;
    end
endfunction

// status and global status read back
function [7:0] rd_byte;
    input [6:0] a;
    reg   [2:0] k;
    begin
        k = grp_of(a);
        if (a == `FHBP_GSTAT_ADDR)
            rd_byte = {2'h0, global_irq_status};
        else if (k != `FHBP_GRP_NONE)
            rd_byte = isr[k];
        else
            rd_byte = regs[a];
    end
endfunction

// events for status group k; group 4 has no sources
function [7:0] evt_grp;
    input [2:0] k;
    begin
        if (k < `FHBP_GRP_HOLE)
            evt_grp = irq_evt_i[8*k +: 8];
        else if (k == `FHBP_GRP_HOLE)
            evt_grp = 8'h00;
        else
            evt_grp = irq_evt_i[39:32];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// address source

wire       ale_fall = ale_q & ~s_ale;
// a tied ale never falls, so the live address stays in use
wire [6:0] addr_eff = ale_seen ? addr_lat : s_addr;
wire [6:0] base     = {addr_eff[6:1], 1'b0};

always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        ale_q    <= 1'b0;
        ale_seen <= 1'b0;
        addr_lat <= 7'h00;
    end else begin
        ale_q <= s_ale;
        if (s_ale)
            addr_lat <= s_addr;
        if (ale_fall)
            ale_seen <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// access decode

wire sep_strobe = ~s_style;
// chip select gate, ORed with the strobe in strobe-plus-direction style
wire sel   = sep_strobe ? ~s_cs_n : ~(s_cs_n | s_rd_n);
wire act_rd = sep_strobe ? (sel & ~s_rd_n) : (sel & s_wr);
wire act_wr = sel & ~s_wr;

// lane selection
reg       lo_en;
reg       hi_en;
reg [6:0] lo_a;
reg [6:0] hi_a;

always @* begin
    lo_a = addr_eff;
    hi_a = addr_eff;
    if (!s_wide) begin
        lo_en = 1'b1;
        hi_en = 1'b0;
    end else if (sep_strobe) begin
        lo_en = ~addr_eff[0];
        hi_en = ~s_be_n;
        lo_a  = base;
        hi_a  = base | 7'h01;
    end else begin
        // lower byte enable, big-endian word order
        lo_en = ~s_be_n;
        hi_en = ~addr_eff[0];
        lo_a  = base | 7'h01;
        hi_a  = base;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path

always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        data_o      <= 16'h0000;
        data_oe_n_o <= 16'hffff;
        rd_q        <= 1'b0;
        r_lo_en     <= 1'b0;
        r_hi_en     <= 1'b0;
        r_lo_a      <= 7'h00;
        r_hi_a      <= 7'h00;
        r_lo_d      <= 8'h00;
        r_hi_d      <= 8'h00;
    end else begin
        rd_q <= act_rd;
        if (act_rd) begin
            data_o  <= {rd_byte(hi_a), rd_byte(lo_a)};
            r_lo_en <= lo_en;
            r_hi_en <= hi_en;
            r_lo_a  <= lo_a;
            r_hi_a  <= hi_a;
            r_lo_d  <= rd_byte(lo_a);
            r_hi_d  <= rd_byte(hi_a);
        end else begin
            data_o <= 16'h0000;
        end
        data_oe_n_o <= {{8{~(act_rd & hi_en)}}, {8{~(act_rd & lo_en)}}};
    end
end

////////////////////////////////////////////////////////////////////////////////
// write path

wire wr_done = wr_q & ~act_wr;
wire rd_done = rd_q & ~act_rd;

integer i;

always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        wr_q    <= 1'b0;
        w_data  <= 16'h0000;
        w_lo_en <= 1'b0;
        w_hi_en <= 1'b0;
        w_lo_a  <= 7'h00;
        w_hi_a  <= 7'h00;
        for (i = 0; i < `FHBP_NREG; i = i + 1) begin
            if (i >= `FHBP_IMR_BASE && i < `FHBP_IMR_BASE + `FHBP_NGRP)
                regs[i] <= `FHBP_IMR_RST;
            else
                regs[i] <= `FHBP_REG_RST;
        end
    end else begin
        wr_q <= act_wr;
        // data is held until the strobe ends, so the last value wins
        if (act_wr) begin
            w_data  <= s_data;
            w_lo_en <= lo_en;
            w_hi_en <= hi_en;
            w_lo_a  <= lo_a;
            w_hi_a  <= hi_a;
        end
        for (i = 0; i < `FHBP_NREG; i = i + 1) begin
            if (wr_done && w_lo_en && w_lo_a == i[6:0])
                regs[i] <= w_data[7:0];
            if (wr_done && w_hi_en && w_hi_a == i[6:0])
                regs[i] <= w_data[15:8];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt status

// clear only bits the host saw, a later event stays pending
function [7:0] clr_grp;
    input [2:0] g;
    begin
        clr_grp = 8'h00;
        if (rd_done && r_lo_en && grp_of(r_lo_a) == g)
            clr_grp = clr_grp | r_lo_d;
        if (rd_done && r_hi_en && grp_of(r_hi_a) == g)
            clr_grp = clr_grp | r_hi_d;
    end
endfunction

integer   k;

always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        for (k = 0; k < `FHBP_NGRP; k = k + 1)
            isr[k] <= 8'h00;
        global_irq_status <= 6'h00;
    end else begin
        for (k = 0; k < `FHBP_NGRP; k = k + 1) begin
            // new events win over the read clear
            isr[k] <= (isr[k] & ~clr_grp(k[2:0])) | evt_grp(k[2:0]);
            global_irq_status[k] <= |(isr[k] & ~regs[`FHBP_IMR_BASE + k[6:0]]);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt pin

reg irq_req;

always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
        irq_req <= 1'b0;
    else
        irq_req <= |global_irq_status;
end

fhbp_irq_pin u_irq (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .req_i      (irq_req),
    .mode_i     (regs[`FHBP_ICFG_ADDR][1:0]),
    .int_o      (int_o),
    .int_oe_n_o (int_oe_n_o)
);

endmodule

//--- dv/fhbp_port_properties.sv
// Purpose: port checks for the framer host bus port
// Assumes: strobes are held six cycles or more per access
// Notes:   lane patterns follow the chosen byte order
`timescale 1ns/1ps
module fhbp_port_chk (
    // clock and reset
    input wire        ref_clk_i,
    input wire        nrst_i,
    // host pins
    input wire        cs_n_i,
    input wire        rd_strobe_n_i,
    input wire        wr_n_dir_i,
    input wire        byte_enable_n_i,
    input wire        bus_style_select_i,
    input wire        bus_width_select_i,
    input wire [6:0]  addr_i,
    // bus answer
    input wire [15:0] data_o,
    input wire [15:0] data_oe_n_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // six samples cover the three-flop filter plus the output register
    sequence s_rd(st, a0, be);
        (!cs_n_i && !rd_strobe_n_i && wr_n_dir_i && bus_width_select_i
            && bus_style_select_i == st && addr_i[0] == a0 && byte_enable_n_i == be)[*6];
    endsequence
    sequence s_wr(st);
        (!cs_n_i && !wr_n_dir_i && rd_strobe_n_i == !st && bus_style_select_i == st)[*6];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_lo;
        s_rd(0, 0, 1) |=> data_oe_n_o == 16'hff00;
    endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("low lane read wrong");
    property p_rd_none;
        s_rd(0, 1, 1) |=> data_oe_n_o == 16'hffff;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("odd read drove a lane");
    property p_rd_hi;
        s_rd(0, 1, 0) |=> data_oe_n_o == 16'h00ff;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper lane read wrong");
    property p_rd_word;
        s_rd(1, 0, 0) |=> data_oe_n_o == 16'h0000;
    endproperty
    a_rd_word: assert property (p_rd_word) else $error("strobe word read wrong");
    property p_narrow;
        (!bus_width_select_i)[*6] |=> data_oe_n_o[15:8] == 8'hff;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper lane on narrow bus");
    property p_idle;
        cs_n_i[*6] |=> data_oe_n_o == 16'hffff && data_o == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("bus driven while deselected");
    property p_wr_sep;
        s_wr(0) |=> data_oe_n_o == 16'hffff;
    endproperty
    a_wr_sep: assert property (p_wr_sep) else $error("bus driven on write");
    property p_wr_dir;
        s_wr(1) |=> data_oe_n_o == 16'hffff;
    endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("bus driven on dir write");
endmodule

bind fhbp_port fhbp_port_chk chk_u (
    .ref_clk_i          (ref_clk_i),
    .nrst_i             (nrst_i),
    .cs_n_i             (cs_n_i),
    .rd_strobe_n_i      (rd_strobe_n_i),
    .wr_n_dir_i         (wr_n_dir_i),
    .byte_enable_n_i    (byte_enable_n_i),
    .bus_style_select_i (bus_style_select_i),
    .bus_width_select_i (bus_width_select_i),
    .addr_i             (addr_i),
    .data_o             (data_o),
    .data_oe_n_o        (data_oe_n_o)
);

//--- dv/fhbp_host.sv
// Purpose: host processor model driving the framer host bus port
// Assumes: straps are stable around each access
// Notes:   undriven data bits read back as a changing pattern
`timescale 1ns/1ps
module fhbp_host (
    // clock and strap
    input  wire        ref_clk_i,
    input  wire        style_i,
    // bus
    output reg         cs_n_o,
    output reg         rd_n_o,
    output reg         wr_n_o,
    output reg         ale_o,
    output reg         be_n_o,
    output reg  [6:0]  addr_o,
    output reg  [15:0] wdata_o,
    input  wire [15:0] data_i,
    input  wire [15:0] oe_n_i,
    // read result
    output reg         done_o,
    output reg  [15:0] rdata_o,
    output reg  [15:0] roe_n_o
);
    reg  [15:0] last = 16'h0;
    wire [15:0] bus = (data_i & ~oe_n_i) | (~last & oe_n_i);

    initial begin
        {cs_n_o, rd_n_o, wr_n_o, be_n_o} = 4'hf;
        {ale_o, done_o, addr_o, wdata_o, rdata_o} = 41'h0;
        roe_n_o = 16'hffff;
    end
    always @(posedge ref_clk_i) begin
        last <= bus;
    end

    task acc(input we, input [6:0] a, input [15:0] d, input bn, input csx, input mux);
        begin
            @(negedge ref_clk_i);
            if (mux) begin
                ale_o  <= 1'b1;
                addr_o <= a;
                repeat (4) @(negedge ref_clk_i);
                ale_o  <= 1'b0;
                repeat (4) @(negedge ref_clk_i);
            end
            addr_o  <= mux ? a ^ 7'h7e : a;
            wdata_o <= d;
            be_n_o  <= bn;
            cs_n_o  <= csx;
            wr_n_o  <= ~we;
            rd_n_o  <= we & ~style_i;
            repeat (6) @(posedge ref_clk_i);
            rdata_o <= bus;
            roe_n_o <= oe_n_i;
            done_o  <= ~we;
            @(negedge ref_clk_i);
            {cs_n_o, rd_n_o, wr_n_o, done_o} <= 4'he;
            repeat (6) @(negedge ref_clk_i);
        end
    endtask
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench for the framer host bus port
// Assumes: host model spaces accesses by at least seven idle cycles
// Notes:   reads are noted in a queue and matched as they complete
`timescale 1ns/1ps
module tb_top;
    reg         ref_clk_i = 1'b0;
    reg         nrst_i    = 1'b0;
    reg         style     = 1'b0;
    reg         width     = 1'b0;
    reg         mux       = 1'b0;
    reg  [39:0] irq_evt   = 40'h0;
    wire        cs_n, rd_n, wr_n, ale, be_n, rd_done, int_o, int_oe_n;
    wire [6:0]  addr;
    wire [15:0] wdata, data_o, oe_n, rd_data, rd_oe_n;
    reg  [7:0]  mem [0:127];
    reg  [31:0] q [$];
    reg  [31:0] exp_v;
    reg  [31:0] r;
    reg  [6:0]  a;
    reg  [1:0]  md;
    integer     err_total = 0;
    integer     checks    = 0;
    integer     i, m, k;

    always #5 ref_clk_i = ~ref_clk_i;

    fhbp_port dut_u (
        .ref_clk_i          (ref_clk_i),
        .nrst_i             (nrst_i),
        .cs_n_i             (cs_n),
        .rd_strobe_n_i      (rd_n),
        .wr_n_dir_i         (wr_n),
        .ale_i              (ale),
        .byte_enable_n_i    (be_n),
        .bus_style_select_i (style),
        .bus_width_select_i (width),
        .addr_i             (addr),
        .data_i             (wdata),
        .data_o             (data_o),
        .data_oe_n_o        (oe_n),
        .irq_evt_i          (irq_evt),
        .int_o              (int_o),
        .int_oe_n_o         (int_oe_n)
    );
    fhbp_host host_u (
        .ref_clk_i (ref_clk_i),
        .style_i   (style),
        .cs_n_o    (cs_n),
        .rd_n_o    (rd_n),
        .wr_n_o    (wr_n),
        .ale_o     (ale),
        .be_n_o    (be_n),
        .addr_o    (addr),
        .wdata_o   (wdata),
        .data_i    (data_o),
        .oe_n_i    (oe_n),
        .done_o    (rd_done),
        .rdata_o   (rd_data),
        .roe_n_o   (rd_oe_n)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] want);
        begin
            checks = checks + 1;
            if (got !== want) begin
                err_total = err_total + 1;
                $display("mismatch at %0t got %h want %h", $time, got, want);
            end
        end
    endtask
    task test_done;
        begin
            if (q.size() != 0)
                err_total = err_total + 1;
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // reference lanes: style 1 puts the even register on the upper lane
    task op(input we, input [6:0] ad, input [15:0] d, input bn, input csx);
        reg lo;
        reg hi;
        reg [6:0] la;
        reg [6:0] ha;
        begin
            lo = ~csx & (~width | (style ? ~bn : ~ad[0]));
            hi = ~csx & width & (style ? ~ad[0] : ~bn);
            la = width ? {ad[6:1], style} : ad;
            ha = {ad[6:1], ~style};
            if (we && lo)
                mem[la] = d[7:0];
            if (we && hi)
                mem[ha] = d[15:8];
            if (!we)
                q.push_back({~{{8{hi}}, {8{lo}}}, hi ? mem[ha] : 8'h00, lo ? mem[la] : 8'h00});
            host_u.acc(we, ad, d, bn, csx, mux);
        end
    endtask
    // results settle at the rising edge, so they are taken half a cycle later
    always @(negedge ref_clk_i) begin
        if (rd_done === 1'b1) begin
            exp_v = q.pop_front();
            chk({rd_oe_n, rd_data & ~rd_oe_n}, exp_v);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (i = 0; i < 128; i = i + 1)
            mem[i] = (i >= 32 && i < 38) ? 8'hff : 8'h00;
        r = $urandom(24);
        repeat (20) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        op(0, 7'h00, 16'h0, 1'b1, 1'b0);
        op(0, 7'h08, 16'h0, 1'b1, 1'b0);
        op(0, 7'h20, 16'h0, 1'b1, 1'b0);
        op(0, 7'h25, 16'h0, 1'b1, 1'b0);
        op(0, 7'h6e, 16'h0, 1'b1, 1'b0);
        $display("test reset values done");
        for (m = 0; m < 4; m = m + 1) begin
            style = m[1];
            width = m[0];
            repeat (4) @(negedge ref_clk_i);
            for (k = 0; k < 4; k = k + 1) begin
                r = $urandom;
                a = {2'h2, r[20:17], k[0]};
                op(1, a, r[15:0], r[16], 1'b0);
                op(0, a, 16'h0, k[1], 1'b0);
            end
            $display("test straps %0d done", m);
        end
        op(1, 7'h41, 16'h5aa5, 1'b0, 1'b1);
        op(0, 7'h41, 16'h0, 1'b0, 1'b1);
        op(0, 7'h41, 16'h0, 1'b0, 1'b0);
        $display("test deselect done");
        style = 1'b0;
        width = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        op(1, 7'h20, 16'h00fe, 1'b0, 1'b0);
        for (m = 0; m < 3; m = m + 1) begin
            md = (m == 0) ? 2'h1 : (m == 1) ? 2'h3 : 2'h0;
            op(1, 7'h08, {14'h0, md}, 1'b1, 1'b0);
            irq_evt[0] = 1'b1;
            @(negedge ref_clk_i);
            irq_evt[0] = 1'b0;
            repeat (8) @(negedge ref_clk_i);
            chk({30'h0, int_oe_n, int_o}, {31'h0, md == 2'h3});
            mem[7'h6e] = 8'h01;
            mem[7'h68] = 8'h01;
            op(0, 7'h6e, 16'h0, 1'b1, 1'b0);
            op(0, 7'h68, 16'h0, 1'b1, 1'b0);
            mem[7'h6e] = 8'h00;
            mem[7'h68] = 8'h00;
            repeat (8) @(negedge ref_clk_i);
            chk({30'h0, int_oe_n, int_o}, {30'h0, md == 2'h0, md == 2'h1});
        end
        $display("test interrupt done");
        width = 1'b1;
        mux   = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        for (k = 0; k < 4; k = k + 1) begin
            r = $urandom;
            a = {3'h5, r[3:0]};
            op(1, a, r[31:16], 1'b0, 1'b0);
            op(0, a, 16'h0, 1'b0, 1'b0);
        end
        $display("test address latch done");
        test_done;
    end
    // about a thousand cycles are expected, so six thousand marks a hang
    initial begin
        #60000;
        err_total = err_total + 1;
        test_done;
    end
endmodule
